// ### bench/tb_top.sv
// Self-checking bench for the frame-sync PLL and PWM input config bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef struct {logic [9:0] adr; logic [7:0] wd; logic [31:0] ex;} vpc_row_t;
  typedef struct {logic [1:0] m; logic [11:0] d; logic [11:0] ex;} vpc_hys_t;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [9:0] wbAdr = 10'h000;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut, rd;
  logic wbAck, pllTick, frameSync, pllRefFrameSync, pllTrimUp, pllTrimDown, pllLocked;
  logic [2:0] resistorRate = 3'h3, pwmRate;
  logic [11:0] pwmInDuty = 12'h800, filteredDuty;
  logic [1:0] pllFreqSel;
  logic [12:0] pllDivider;
  logic [20:0] ticksPerFrame = 21'h1A;
  int n_fail = 0, checked = 0, nUp, nDn;
  int fac[4] = '{26, 50, 98, 196};
  vpc_row_t rows[5] = '{'{10'h294, 8'h7F, 32'h7F}, '{10'h298, 8'hAB, 32'hAB},
    '{10'h29C, 8'hFF, 32'hFF}, '{10'h300, 8'hFF, 32'h1F}, '{10'h3FC, 8'hFF, 32'h0}};
  vpc_hys_t hys[6] = '{'{2'h0, 12'h800, 12'h800}, '{2'h1, 12'h801, 12'h800},
    '{2'h1, 12'h808, 12'h808}, '{2'h2, 12'h80A, 12'h808},
    '{2'h2, 12'h810, 12'h810}, '{2'h0, 12'h811, 12'h811}};

  // Clock
  always #4 ref_clk = ~ref_clk;

  vpc_sync_cfg u_vpc_sync_cfg (.ref_clk, .arst_n, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
    .wbDatIn, .wbDatOut, .wbAck, .frameSync, .pllTick, .resistorRate, .pwmInDuty,
    .pllRefFrameSync, .pllFreqSel, .pllDivider, .pllTrimUp, .pllTrimDown, .pllLocked,
    .pwmRate, .filteredDuty);
  vpc_frame_src u_vpc_frame_src (.ref_clk, .arst_n, .ticksPerFrame, .pllTick, .frameSync);

  // ==========================================================
  // Helpers
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatIn <= {24'h0, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    if (wbAck !== 1'b1) begin
      $display("FAIL wbAck expected 1 seen no answer");
      n_fail++;
      tally_and_finish();
    end
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      wb(1'b1, rows[i].adr, rows[i].wd);
      wb(1'b0, rows[i].adr, 8'h0);
      check("register", rd, rows[i].ex);
    end
    $display("test registers done");
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 10'h29C, 8'h0);
    check("reset value", rd, 32'h0);
    $display("test reset done");
    wb(1'b1, 10'h298, 8'h01);
    wb(1'b1, 10'h29C, 8'h28);
    repeat (3) @(posedge ref_clk);
    check("divider off", 32'(pllDivider), 32'h0);
    wb(1'b1, 10'h294, 8'h80);
    repeat (3) @(posedge ref_clk);
    check("divider on", 32'(pllDivider), 32'h25);
    check("reference", 32'(pllRefFrameSync), 32'h1);
    $display("test divider done");
    wb(1'b1, 10'h298, 8'h00);
    wb(1'b1, 10'h29C, 8'h08);
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, 10'h300, 8'(d));
      ticksPerFrame <= 21'(fac[d]);
      repeat (4 * fac[d]) @(posedge ref_clk);
      check("freq select", 32'(pllFreqSel), 32'(d));
      check("locked", 32'(pllLocked), 32'h1);
    end
    for (int k = 0; k < 2; k++) begin
      ticksPerFrame <= 21'(195 + 2 * k);
      repeat (400) @(posedge ref_clk);
      nUp = 0;
      nDn = 0;
      repeat (600) begin
        @(posedge ref_clk);
        nUp += int'(pllTrimUp === 1'b1);
        nDn += int'(pllTrimDown === 1'b1);
      end
      check("trim", {30'h0, nDn > 0, nUp > 0}, (k == 0) ? 32'h1 : 32'h2);
      check("unlocked", 32'(pllLocked), 32'h0);
    end
    $display("test frame lock done");
    wb(1'b1, 10'h300, 8'h17);
    repeat (3) @(posedge ref_clk);
    check("stored rate", 32'(pwmRate), 32'h5);
    wb(1'b1, 10'h29C, 8'h0C);
    repeat (3) @(posedge ref_clk);
    check("resistor rate", 32'(pwmRate), 32'h3);
    wb(1'b0, 10'h304, 8'h0);
    check("status", rd, 32'h3E);
    $display("test rate select done");
    foreach (hys[i]) begin
      wb(1'b1, 10'h29C, {6'h02, hys[i].m});
      pwmInDuty <= hys[i].d;
      repeat (4) @(posedge ref_clk);
      check("filtered duty", 32'(filteredDuty), 32'(hys[i].ex));
    end
    wb(1'b0, 10'h308, 8'h0);
    check("duty register", rd, 32'h811);
    $display("test hysteresis done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ### bench/vpc_frame_src.sv
// Frame-sync source model: PLL tick strobe and frame start pulses
`timescale 1ns/100ps
`default_nettype none
module vpc_frame_src (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [20:0] ticksPerFrame,
  output logic pllTick,
  output logic frameSync
);
  logic [20:0] cnt;
  // ==========================================================
  // Frame pulses
  // One tick per cycle, one-cycle frame pulse every period
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 21'h0;
      pllTick <= 1'b0;
      frameSync <= 1'b0;
    end else begin
      pllTick <= 1'b1;
      frameSync <= (cnt == 21'h0);
      cnt <= (cnt >= ticksPerFrame - 21'h1) ? 21'h0 : cnt + 21'h1;
    end
  end
endmodule
`default_nettype wire

// ### design/vpc_duty_filter.sv
// PWM input duty hysteresis filter
`timescale 1ns/100ps
`default_nettype none
module vpc_duty_filter #(
  parameter int DUTY_W = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [DUTY_W-1:0] dutyIn,
  input wire logic [1:0] hystMode,
  output logic [DUTY_W-1:0] dutyOut
);
  typedef struct packed {
    logic [DUTY_W-1:0] held;
  } vpc_filt_t;

  vpc_filt_t st;
  vpc_filt_t next_st;
  logic [DUTY_W-1:0] diff;
  logic [DUTY_W-1:0] coarse;
  logic active;

  // ==========================================================
  // Hysteresis decision
  always_comb begin
    next_st = st;
    diff = (dutyIn > st.held) ? dutyIn - st.held : st.held - dutyIn;
    active = (hystMode == vpc_pkg::HYST_RES11) || (hystMode == vpc_pkg::HYST_RES10);
    if (hystMode == vpc_pkg::HYST_RES11) begin
      coarse = diff >> (DUTY_W - vpc_pkg::HYST_RES11_BITS);
    end else begin
      coarse = diff >> (DUTY_W - vpc_pkg::HYST_RES10_BITS);
    end
    if (!active) begin
      next_st.held = dutyIn;
    end else if (coarse > 1) begin
      next_st.held = dutyIn;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dutyOut = st.held;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  AST_HYST_OFF_TRACKS: assert property (!active |=> st.held == $past(dutyIn))
    else $error("duty not passed through with hysteresis off");
  AST_HYST_SMALL_HOLD: assert property (active && coarse <= 1 |=> $stable(st.held))
    else $error("small duty change not ignored");
  AST_HYST_BIG_MOVE: assert property (active && coarse > 1 |=> st.held == $past(dutyIn))
    else $error("large duty change not followed");
endmodule
`default_nettype wire

// ### design/vpc_pkg.sv
// Constants for the frame-sync PLL and PWM input configuration bank
// Functional notes
// - Divider low five bits live in bits 7:3.
// - Divider applies only with frame sync enabled.
// - Selector 0 takes rate from stored bits.
// - Selector 1 takes rate from resistor.
// - Hysteresis field: off, 11-bit, 10-bit.
// - Active hysteresis ignores small duty changes.
// - PLL frequency chosen by depth select bits.
// - Frame sync becomes PLL reference when enabled.
// - Divider high eight bits in preceding register.
package vpc_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_SYNC_CTRL = 8'hA5;
  localparam logic [7:0] IDX_DIV_HIGH = 8'hA6;
  localparam logic [7:0] IDX_DIV_LOW = 8'hA7;
  localparam logic [7:0] IDX_RATE_CFG = 8'hC0;
  localparam logic [7:0] IDX_STATUS = 8'hC1;
  localparam logic [7:0] IDX_DUTY = 8'hC2;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_SYNC_CTRL = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_DIV_LOW = 8'h00;
  localparam logic [4:0] RST_RATE_CFG = 5'h00;
  // ==========================================================
  // Field positions
  localparam int FS_EN_BIT = 7;
  localparam int DIV_LOW_MSB = 7;
  localparam int DIV_LOW_LSB = 3;
  localparam int RES_SEL_BIT = 2;
  localparam int HYST_MSB = 1;
  localparam int HYST_LSB = 0;
  localparam int CFG_DEPTH_MSB = 1;
  localparam int CFG_DEPTH_LSB = 0;
  localparam int CFG_RATE_MSB = 4;
  localparam int CFG_RATE_LSB = 2;
  // ==========================================================
  // Widths
  localparam int DIV_W = 13;
  localparam int RATE_W = 3;
  localparam int ACC_W = 21;
  // ==========================================================
  // Hysteresis encodings
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_RES11 = 2'h1;
  localparam logic [1:0] HYST_RES10 = 2'h2;
  localparam int HYST_RES11_BITS = 11;
  localparam int HYST_RES10_BITS = 10;
  // ==========================================================
  // Frame-sync factors per PLL frequency (5, 10, 20, 40 MHz)
  localparam logic [7:0] FACTOR_5M = 8'h1A;
  localparam logic [7:0] FACTOR_10M = 8'h32;
  localparam logic [7:0] FACTOR_20M = 8'h62;
  localparam logic [7:0] FACTOR_40M = 8'hC4;
endpackage

// ### design/vpc_sync_cfg.sv
// Frame-sync PLL divider and PWM input configuration bank, Wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module vpc_sync_cfg #(
  parameter int DUTY_W = 12
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [9:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic frameSync,
  input wire logic pllTick,
  input wire logic [2:0] resistorRate,
  input wire logic [DUTY_W-1:0] pwmInDuty,
  output logic pllRefFrameSync,
  output logic [1:0] pllFreqSel,
  output logic [12:0] pllDivider,
  output logic pllTrimUp,
  output logic pllTrimDown,
  output logic pllLocked,
  output logic [2:0] pwmRate,
  output logic [DUTY_W-1:0] filteredDuty
);
  typedef struct packed {
    logic [7:0] syncCtrl;
    logic [7:0] divHigh;
    logic [7:0] divLow;
    logic [4:0] rateCfg;
    logic ack;
    logic [31:0] rdData;
    logic syncPrev;
    logic [20:0] tickCnt;
    logic trimUp;
    logic trimDown;
    logic locked;
    logic refSync;
    logic [1:0] freqSel;
    logic [12:0] divApplied;
    logic [2:0] rate;
    logic [DUTY_W-1:0] duty;
  } vpc_state_t;

  vpc_state_t st;
  vpc_state_t next_st;
  logic access;
  logic wrTake;
  logic syncRise;
  logic [20:0] target;
  logic [DUTY_W-1:0] filtDuty;

  // Word address match for a register index
  function automatic logic wrHit(input logic [9:0] adr, input logic [7:0] idx);
    wrHit = (adr[9:2] == idx);
  endfunction

  // Frame-sync factor for the selected PLL frequency
  function automatic logic [7:0] factorOf(input logic [1:0] sel);
    unique case (sel)
      2'h0: factorOf = vpc_pkg::FACTOR_5M;
      2'h1: factorOf = vpc_pkg::FACTOR_10M;
      2'h2: factorOf = vpc_pkg::FACTOR_20M;
      2'h3: factorOf = vpc_pkg::FACTOR_40M;
    endcase
  endfunction

  // ==========================================================
  // Duty hysteresis
  vpc_duty_filter #(
    .DUTY_W(DUTY_W)
  ) u_filter (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .dutyIn(pwmInDuty),
    .hystMode(st.divLow[vpc_pkg::HYST_MSB:vpc_pkg::HYST_LSB]),
    .dutyOut(filtDuty)
  );

  // ==========================================================
  // Bus slave, configuration and lock tracking
  always_comb begin
    next_st = st;
    access = wbCyc && wbStb;
    wrTake = access && st.ack && wbWe && wbSel[0];
    syncRise = frameSync && !st.syncPrev;
    target = {8'h00, st.divApplied} * {13'h0000, factorOf(st.freqSel)};
    // Single-cycle acknowledge with registered read data
    next_st.ack = access && !st.ack;
    next_st.rdData = 32'h0000_0000;
    if (access && !st.ack && !wbWe) begin
      unique case (wbAdr[9:2])
        vpc_pkg::IDX_SYNC_CTRL: next_st.rdData = {24'h000000, st.syncCtrl};
        vpc_pkg::IDX_DIV_HIGH: next_st.rdData = {24'h000000, st.divHigh};
        vpc_pkg::IDX_DIV_LOW: next_st.rdData = {24'h000000, st.divLow};
        vpc_pkg::IDX_RATE_CFG: next_st.rdData = {27'h0000000, st.rateCfg};
        vpc_pkg::IDX_STATUS: next_st.rdData = {25'h0000000, st.rate, st.freqSel,
                                               st.refSync, st.locked};
        vpc_pkg::IDX_DUTY: next_st.rdData = {{(32-DUTY_W){1'b0}}, st.duty};
        default: next_st.rdData = 32'h0000_0000;
      endcase
    end
    // Writes commit on the edge where the master sees ack
    if (wrTake && wrHit(wbAdr, vpc_pkg::IDX_SYNC_CTRL)) begin
      next_st.syncCtrl = wbDatIn[7:0];
    end
    if (wrTake && wrHit(wbAdr, vpc_pkg::IDX_DIV_HIGH)) begin
      next_st.divHigh = wbDatIn[7:0];
    end
    if (wrTake && wrHit(wbAdr, vpc_pkg::IDX_DIV_LOW)) begin
      next_st.divLow = wbDatIn[7:0];
    end
    if (wrTake && wrHit(wbAdr, vpc_pkg::IDX_RATE_CFG)) begin
      next_st.rateCfg = wbDatIn[4:0];
    end
    // PLL reference, frequency and divider
    next_st.refSync = st.syncCtrl[vpc_pkg::FS_EN_BIT];
    next_st.freqSel = st.rateCfg[vpc_pkg::CFG_DEPTH_MSB:vpc_pkg::CFG_DEPTH_LSB];
    if (st.syncCtrl[vpc_pkg::FS_EN_BIT]) begin
      next_st.divApplied = {st.divHigh,
                            st.divLow[vpc_pkg::DIV_LOW_MSB:vpc_pkg::DIV_LOW_LSB]};
    end else begin
      next_st.divApplied = 13'h0000;
    end
    // PWM output rate source
    if (st.divLow[vpc_pkg::RES_SEL_BIT]) begin
      next_st.rate = resistorRate;
    end else begin
      next_st.rate = st.rateCfg[vpc_pkg::CFG_RATE_MSB:vpc_pkg::CFG_RATE_LSB];
    end
    next_st.duty = filtDuty;
    // Frame period measured in PLL ticks against divider times factor
    next_st.syncPrev = frameSync;
    next_st.trimUp = 1'b0;
    next_st.trimDown = 1'b0;
    if (!st.refSync) begin
      next_st.tickCnt = 21'h000000;
      next_st.locked = 1'b0;
    end else if (syncRise) begin
      next_st.trimUp = st.tickCnt < target;
      next_st.trimDown = st.tickCnt > target;
      next_st.locked = st.tickCnt == target;
      next_st.tickCnt = pllTick ? 21'h000001 : 21'h000000;
    end else if (pllTick && st.tickCnt != 21'h1FFFFF) begin
      next_st.tickCnt = st.tickCnt + 21'h000001;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.syncCtrl <= vpc_pkg::RST_SYNC_CTRL;
      st.divHigh <= vpc_pkg::RST_DIV_HIGH;
      st.divLow <= vpc_pkg::RST_DIV_LOW;
      st.rateCfg <= vpc_pkg::RST_RATE_CFG;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign wbDatOut = st.rdData;
  assign wbAck = st.ack;
  assign pllRefFrameSync = st.refSync;
  assign pllFreqSel = st.freqSel;
  assign pllDivider = st.divApplied;
  assign pllTrimUp = st.trimUp;
  assign pllTrimDown = st.trimDown;
  assign pllLocked = st.locked;
  assign pwmRate = st.rate;
  assign filteredDuty = st.duty;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Bus handshake
  AST_ACK_SINGLE: assert property (st.ack |=> !st.ack)
    else $error("ack held longer than one cycle");
  AST_ACK_ANSWER: assert property (access && !st.ack |=> st.ack)
    else $error("request not answered in one cycle");

  // Register fields and PLL controls
  AST_DIV_LOW_WRITE: assert property (
      wrTake && wrHit(wbAdr, vpc_pkg::IDX_DIV_LOW) ##1 st.refSync [*2]
      |=> pllDivider[4:0] == $past(wbDatIn[7:3], 3))
    else $error("low divider bits not taken from bits 7:3");
  AST_DIV_HIGH_WRITE: assert property (
      wrTake && wrHit(wbAdr, vpc_pkg::IDX_DIV_HIGH)
      |=> st.divHigh == $past(wbDatIn[7:0]))
    else $error("high divider bits not stored");
  AST_DIV_DISABLED: assert property (!st.syncCtrl[vpc_pkg::FS_EN_BIT] [*3]
      |-> pllDivider == 13'h0000 && !pllLocked)
    else $error("divider applied without frame sync");
  AST_NO_TRIM_OFF: assert property (!st.refSync |=> !pllTrimUp && !pllTrimDown)
    else $error("trim pulse without frame sync reference");
  AST_DIV_CONCAT: assert property (st.syncCtrl[vpc_pkg::FS_EN_BIT]
      |=> pllDivider[12:5] == $past(st.divHigh))
    else $error("high divider bits not on top");
  AST_RATE_STORED: assert property (!st.divLow[vpc_pkg::RES_SEL_BIT]
      |=> pwmRate == $past(st.rateCfg[4:2]))
    else $error("stored rate not used");
  AST_RATE_RESISTOR: assert property (st.divLow[vpc_pkg::RES_SEL_BIT]
      |=> pwmRate == $past(resistorRate))
    else $error("resistor rate not used");
  AST_FREQ_SELECT: assert property ($changed(st.rateCfg[1:0])
      |=> pllFreqSel == $past(st.rateCfg[1:0]))
    else $error("PLL frequency not following depth select");
  AST_REF_SOURCE: assert property ($rose(st.syncCtrl[vpc_pkg::FS_EN_BIT])
      |=> pllRefFrameSync)
    else $error("frame sync not taken as reference");
  AST_LOCK_COMPARE: assert property (st.refSync && syncRise
      |=> (pllLocked == ($past(st.tickCnt) == $past(target)))
      && (pllTrimUp == ($past(st.tickCnt) < $past(target)))
      && !(pllTrimUp && pllTrimDown))
    else $error("frame period compare wrong");
endmodule
`default_nettype wire
